// ===== sim/isx_exec_asserts.sv
// Port checker for isx_exec.
// Assumes file_rdata follows file_addr in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module isx_asserts
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] pc_high_latch,
  input wire logic [7:0] accum,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic [12:0] pc,
  input wire logic pc_load,
  input wire logic flush_next,
  input wire logic busy
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Slots offered while busy are the discarded no-op
  wire tk = instr_valid & ~busy;
  wire [5:0] op = instr[13:8];
  wire br = tk && instr[13:11] == 3'h5;
  a_skip_zero: assert property (tk && op == 6'h3c && file_rdata == 8'hff |=> flush_next && busy) else $error("skip");
  a_skip_none: assert property (tk && op == 6'h3c && file_rdata != 8'hff |=> !flush_next) else $error("noskip");
  a_increment_file_zero: assert property (tk && op == 6'h0a |=> !flush_next && zero_flag == ($past(file_rdata) == 8'hff)) else $error("increment_file");
  a_branch_pc: assert property (br |=> pc_load && pc == {$past(pc_high_latch[4:3]), $past(instr[10:0])}) else $error("pc");
  a_branch_two: assert property (br |=> flush_next && busy) else $error("two");
  a_nop_slot: assert property (busy && instr_valid |=> !busy && !pc_load && !flush_next
    && $stable({accum, zero_flag, carry_flag, pc})) else $error("nop");
  a_flags_kept: assert property (tk && op == 6'h3c || br |=> $stable({zero_flag, carry_flag})) else $error("flags");
  a_or_lit: assert property (tk && op == 6'h38 |=> accum == ($past(accum) | $past(instr[7:0])) && zero_flag == (accum == 8'h00)) else $error("or");
  a_rot_carry: assert property (tk && op == 6'h0d |=> carry_flag == $past(file_rdata[7]) && $stable(zero_flag)) else $error("rot");
endmodule // isx_asserts
bind isx_exec isx_asserts u_chk (.clk, .resetn, .instr_valid, .instr, .file_rdata, .pc_high_latch, .accum, .zero_flag,
  .carry_flag, .pc, .pc_load, .flush_next, .busy);
`default_nettype wire

// ===== sim/isx_exec_tb_top.sv
// Self-checking bench for isx_exec.
// Assumes the file model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module isx_exec_tb_top;
  logic clk = 0, resetn = 0, instr_valid = 0, file_we, zero_flag, carry_flag, pc_load, flush_next, busy;
  logic [13:0] instr = 0;
  logic [7:0] pc_high_latch = 0, file_rdata, file_wdata, accum;
  logic [6:0] file_addr, file_waddr;
  logic [12:0] pc, pc_seq = 13'h0123;
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #10 clk = ~clk;
  isx_exec dut (.clk, .resetn, .instr_valid, .instr, .file_rdata, .pc_high_latch, .pc_seq, .file_addr,
    .file_wdata, .file_we, .file_waddr, .accum, .zero_flag, .carry_flag, .pc, .pc_load, .flush_next, .busy);
  isx_file_model fm (.clk, .file_addr, .file_we, .file_waddr, .file_wdata, .file_rdata);
  task automatic chk(input logic [23:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("%0d mismatches in %0d checks", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic exe(input logic [13:0] i);
    @(posedge clk);
    #1 instr = i;
    instr_valid = 1;
    @(posedge clk);
    #1 instr_valid = 0;
  endtask
  // Whole run is about 45 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      results;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    #1 resetn = 1;
    fm.mem[5] = 8'hff;
    fm.mem[6] = 8'hff;
    fm.mem[7] = 8'h10;
    fm.mem[8] = 8'h81;
    exe(14'h3800);
    chk({zero_flag, accum}, 9'h100);
    exe(14'h38a4);
    chk({zero_flag, accum}, 9'h0a4);
    exe(14'h3c85);
    chk({flush_next, busy, file_we, file_waddr, file_wdata}, {3'h7, 7'h05, 8'h00});
    exe(14'h38ff);
    chk({busy, zero_flag, accum}, 10'h0a4);
    exe(14'h3c05);
    chk({flush_next, zero_flag, accum}, 10'h001);
    chk(pc, 13'h0123);
    exe(14'h0a06);
    chk({flush_next, zero_flag, accum}, 10'h100);
    exe(14'h0487);
    chk({file_we, file_waddr, file_wdata, zero_flag}, {1'b1, 7'h07, 8'h10, 1'b0});
    exe(14'h0d08);
    chk({carry_flag, zero_flag, accum}, 10'h202);
    exe(14'h0d08);
    chk({carry_flag, accum}, 9'h103);
    pc_high_latch = 8'h18;
    exe(14'h2fff);
    chk({pc_load, flush_next, carry_flag, zero_flag, pc}, {4'he, 13'h1fff});
    exe(14'h0000);
    chk({busy, pc_load, pc}, {2'b00, 13'h1fff});
    pc_high_latch = 8'h08;
    exe(14'h2800);
    chk(pc, 13'h0800);
    results;
  end
endmodule // isx_exec_tb_top
`default_nettype wire

// ===== sim/isx_file_model.sv
// File register model behind the execution block.
// Assumes writes land at the edge after file_we.
`timescale 1ns/100ps
`default_nettype none
module isx_file_model
(
  input wire logic clk,
  input wire logic [6:0] file_addr,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [0:127];
  assign file_rdata = mem[file_addr];
  always @(posedge clk)
    if (file_we)
      mem[file_waddr] <= file_wdata;
endmodule // isx_file_model
`default_nettype wire

// ===== verilog/isx_defs.vh
// Constants for the increment/skip/branch/or/rotate execution block.
// Assumes a 14-bit instruction word, 8-bit data and a 13-bit program counter.
// Overview of operation
// - 7-bit file address; destination bit picks target
// - Increment-skip writes result, zero result skips next
// - Nonzero increment-skip result executes next instruction normally
// - Branch loads 11-bit immediate into counter low
// - Counter bits 12:11 from high latch 4:3
// - Branch takes two cycles, flags untouched
// - OR literal into accumulator, update zero
// - Increment file writes destination, updates zero, never skips
// - OR accumulator with file, update zero
// - Rotate left through carry into destination, only carry flag changes
`ifndef ISX_DEFS_VH
`define ISX_DEFS_VH
// Opcode patterns are this core's own encoding choice
`define ISX_OPC_INC_SKIP 14'h3c00
`define ISX_OPC_INC_FILE 14'h0a00
`define ISX_OPC_OR_FILE 14'h0400
`define ISX_OPC_ROTATE 14'h0d00
`define ISX_OPC_OR_LIT 14'h3800
`define ISX_OPC_BRANCH 14'h2800
`define ISX_MASK_FD 14'h3f00
`define ISX_MASK_LIT 14'h3f00
`define ISX_MASK_BR 14'h3800
`define ISX_ADDR_MSB 6
`define ISX_DEST_BIT 7
`define ISX_LIT_MSB 7
`define ISX_K_MSB 10
`define ISX_LATCH_HI 4
`define ISX_LATCH_LO 3
`define ISX_DATA_MSB 7
`define ISX_ROT_MSB 6
`define ISX_ONE 8'h01
`define ISX_ZERO 8'h00
`define ISX_ADDR_RESET 7'h00
`define ISX_PC_RESET 13'h0000
`endif

// ===== verilog/isx_exec.v
// Execution unit for increment-skip, increment, branch, OR and rotate-left.
// Assumes instr_valid pulses once per instruction cycle (enable from the core
// divider); file register read data is valid combinationally for file_addr.
// Assumes pc_seq holds the address of the next sequential instruction.
`timescale 1ns/100ps
`default_nettype none
`include "isx_defs.vh"
module isx_exec
(
  input wire clk,
  input wire resetn,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire [7:0] file_rdata,
  input wire [7:0] pc_high_latch,
  input wire [12:0] pc_seq,
  output wire [6:0] file_addr,
  output wire [7:0] file_wdata,
  output wire file_we,
  output wire [6:0] file_waddr,
  output wire [7:0] accum,
  output wire zero_flag,
  output wire carry_flag,
  output wire [12:0] pc,
  output wire pc_load,
  output wire flush_next,
  output wire busy
);
  ////////////////////////////////////////////////////////////////////////////
  // One-hot states; ST_NOP is the discarded slot after a skip or branch
  localparam ST_RUN = 2'b01;
  localparam ST_NOP = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded instruction classes and fields
  wire is_increment_skip_if_zero;
  wire is_increment_file;
  wire is_or_accumulator_file;
  wire is_rotate_left_through_carry;
  wire is_or_literal_accumulator;
  wire is_unconditional_branch;
  wire is_file_op;
  wire dest_file;
  wire take_slot;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and their next values
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [7:0] accum_reg;
  reg [7:0] accum_next;
  reg zero_reg;
  reg zero_next;
  reg carry_reg;
  reg carry_next;
  reg file_we_reg;
  reg file_we_next;
  reg [6:0] file_waddr_reg;
  reg [6:0] file_waddr_next;
  reg [7:0] file_wdata_reg;
  reg [7:0] file_wdata_next;
  reg [12:0] pc_reg;
  reg [12:0] pc_next;
  reg pc_load_reg;
  reg pc_load_next;
  reg skip_flush_reg;
  reg skip_flush_next;

  // Datapath results of the instruction in the current slot
  reg [7:0] result;
  reg write_file;
  reg write_acc;
  reg upd_zero;
  reg upd_carry;
  reg new_carry;
  reg skip;

  ////////////////////////////////////////////////////////////////////////////
  function zero_of;
    input [7:0] v;
    begin
      zero_of = (v == `ISX_ZERO);
    end
  endfunction

  // Wraps at 8 bits, so an all-ones operand gives zero and the skip test fires
  function [7:0] inc_of;
    input [7:0] v;
    begin
      inc_of = v + `ISX_ONE;
    end
  endfunction

  // Only two latch bits reach the counter; the rest of the latch is ignored
  function [12:0] branch_target;
    input [7:0] latch;
    input [10:0] k;
    begin
      branch_target = {latch[`ISX_LATCH_HI:`ISX_LATCH_LO], k};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  isx_opdec u_dec
  (
    .instr(instr),
    .is_increment_skip_if_zero(is_increment_skip_if_zero),
    .is_increment_file(is_increment_file),
    .is_or_accumulator_file(is_or_accumulator_file),
    .is_rotate_left_through_carry(is_rotate_left_through_carry),
    .is_or_literal_accumulator(is_or_literal_accumulator),
    .is_unconditional_branch(is_unconditional_branch)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign file_addr = instr[`ISX_ADDR_MSB:0];
  assign dest_file = instr[`ISX_DEST_BIT];
  assign is_file_op = is_increment_skip_if_zero | is_increment_file |
    is_or_accumulator_file | is_rotate_left_through_carry;
  // A slot offered in the second cycle of a skip or branch is thrown away
  assign take_slot = instr_valid & (state_reg == ST_RUN);
  assign busy = (state_reg == ST_NOP);

  // Outputs straight from flip-flops
  assign file_wdata = file_wdata_reg;
  assign file_we = file_we_reg;
  assign file_waddr = file_waddr_reg;
  assign accum = accum_reg;
  assign zero_flag = zero_reg;
  assign carry_flag = carry_reg;
  assign pc = pc_reg;
  assign pc_load = pc_load_reg;
  assign flush_next = skip_flush_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Result, destination and flag selection for the decoded class
  always @*
  begin
    result = `ISX_ZERO;
    write_file = 1'b0;
    write_acc = 1'b0;
    upd_zero = 1'b0;
    upd_carry = 1'b0;
    new_carry = carry_reg;
    skip = 1'b0;
    if (is_increment_skip_if_zero)
    begin
      result = inc_of(file_rdata);
      skip = zero_of(result);
    end
    else if (is_increment_file)
    begin
      result = inc_of(file_rdata);
      upd_zero = 1'b1;
    end
    else if (is_or_accumulator_file)
    begin
      result = accum_reg | file_rdata;
      upd_zero = 1'b1;
    end
    else if (is_rotate_left_through_carry)
    begin
      result = {file_rdata[`ISX_ROT_MSB:0], carry_reg};
      new_carry = file_rdata[`ISX_DATA_MSB];
      upd_carry = 1'b1;
    end
    else if (is_or_literal_accumulator)
    begin
      result = accum_reg | instr[`ISX_LIT_MSB:0];
      upd_zero = 1'b1;
    end
    if (is_file_op)
    begin
      write_file = dest_file;
      write_acc = ~dest_file;
    end
    if (is_or_literal_accumulator)
      write_acc = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  always @*
  begin
    case (state_reg)
      ST_RUN:
        state_next = (take_slot && (skip || is_unconditional_branch)) ? ST_NOP : ST_RUN;
      ST_NOP:
        state_next = instr_valid ? ST_RUN : ST_NOP;
      default:
        state_next = ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Only a taken slot changes anything; pulses drop back after one cycle
  always @*
  begin
    accum_next = accum_reg;
    zero_next = zero_reg;
    carry_next = carry_reg;
    file_we_next = 1'b0;
    file_waddr_next = file_waddr_reg;
    file_wdata_next = file_wdata_reg;
    pc_next = pc_reg;
    pc_load_next = 1'b0;
    skip_flush_next = 1'b0;
    if (take_slot)
    begin
      if (write_acc)
        accum_next = result;
      if (write_file)
      begin
        file_we_next = 1'b1;
        file_waddr_next = file_addr;
        file_wdata_next = result;
      end
      if (upd_zero)
        zero_next = zero_of(result);
      if (upd_carry)
        carry_next = new_carry;
      if (is_unconditional_branch)
      begin
        pc_next = branch_target(pc_high_latch, instr[`ISX_K_MSB:0]);
        pc_load_next = 1'b1;
        skip_flush_next = 1'b1;
      end
      else
      begin
        pc_next = pc_seq;
        skip_flush_next = skip;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_RUN;
      accum_reg <= `ISX_ZERO;
      zero_reg <= 1'b0;
      carry_reg <= 1'b0;
      file_we_reg <= 1'b0;
      file_waddr_reg <= `ISX_ADDR_RESET;
      file_wdata_reg <= `ISX_ZERO;
      pc_reg <= `ISX_PC_RESET;
      pc_load_reg <= 1'b0;
      skip_flush_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      accum_reg <= accum_next;
      zero_reg <= zero_next;
      carry_reg <= carry_next;
      file_we_reg <= file_we_next;
      file_waddr_reg <= file_waddr_next;
      file_wdata_reg <= file_wdata_next;
      pc_reg <= pc_next;
      pc_load_reg <= pc_load_next;
      skip_flush_reg <= skip_flush_next;
    end
  end
endmodule // isx_exec
`default_nettype wire

// ===== verilog/isx_opdec.v
// Instruction decoder for the execution block: one-hot class outputs.
// Assumes a 14-bit instruction word on the same clock, combinational use.
`timescale 1ns/100ps
`default_nettype none
`include "isx_defs.vh"
module isx_opdec
(
  input wire [13:0] instr,
  output wire is_increment_skip_if_zero,
  output wire is_increment_file,
  output wire is_or_accumulator_file,
  output wire is_rotate_left_through_carry,
  output wire is_or_literal_accumulator,
  output wire is_unconditional_branch
);
  assign is_increment_skip_if_zero = (instr & `ISX_MASK_FD) == `ISX_OPC_INC_SKIP;
  assign is_increment_file = (instr & `ISX_MASK_FD) == `ISX_OPC_INC_FILE;
  assign is_or_accumulator_file = (instr & `ISX_MASK_FD) == `ISX_OPC_OR_FILE;
  assign is_rotate_left_through_carry = (instr & `ISX_MASK_FD) == `ISX_OPC_ROTATE;
  assign is_or_literal_accumulator = (instr & `ISX_MASK_LIT) == `ISX_OPC_OR_LIT;
  assign is_unconditional_branch = (instr & `ISX_MASK_BR) == `ISX_OPC_BRANCH;
endmodule // isx_opdec
`default_nettype wire
